/* verilog/rcc_top.sv */
// reset controller: reset merge, keyed configuration commit, cause flags
`timescale 1ns/10ps
`default_nettype none

// How it works
// - key 0xb2 commits pending external reset disable bit
// - key 0xd4 commits pending reset area and reset vector bits
// - key 0x71 acts on flag clear request; other key values do nothing
// - readback at 0x0fdf shows committed vector, area, disable; upper zero
// - configuration register reads zero in bits 7 to 3
// - committed disable cleared by power-on only; pending by any reset
// - cause bits 0..5: watchdog, clock, vdet1, vdet2, trim, bad trim
// - cause flags cleared by power-on, external reset or keyed clear
// - flag clear bit then key 0x71 clears flags and the clear bit
// - cause bit 7 is write-only clear control; bits 7, 6 read zero
// - any reset holds warm-up counter, cpu and peripherals in reset
// - reset release starts warm-up counting of high-frequency clock
// - trimming data is loaded into the ladder during warm-up
// - after warm-up the cpu fetches the vector at 0xfffe
// - reset during warm-up clears the counter so warm-up restarts
// - every reset source runs the same sequence
// - committed disable 0 accepts external reset, 1 ignores it
// - power-on and external reset are ored together
module rcc_top #(
  parameter int WARMUP_CYCLES = rcc_pkg::WARMUP_CYCLES_DEF,
  parameter int TRIM_W        = rcc_pkg::TRIM_W_DEF
) (
  input  wire logic                        core_clk_i,
  input  wire logic                        rst_n_i,
  input  wire logic                        ext_reset_n_i,
  input  wire logic                        wdt_reset_i,
  input  wire logic                        clk_fault_reset_i,
  input  wire logic                        vdet1_reset_i,
  input  wire logic                        vdet2_reset_i,
  input  wire logic                        trim_reset_i,
  input  wire logic                        bad_trim_i,
  input  wire logic                        trim_valid_i,
  input  wire logic [TRIM_W-1:0]           trim_data_i,
  input  wire logic [rcc_pkg::ADDR_W-1:0]  addr_i,
  input  wire logic [rcc_pkg::DATA_W-1:0]  wr_data_i,
  input  wire logic                        wr_i,
  input  wire logic                        rd_i,
  output logic      [rcc_pkg::DATA_W-1:0]  rd_data_o,
  output logic                             cpu_reset_n_o,
  output logic                             periph_reset_n_o,
  output logic                             warmup_active_o,
  output logic                             vector_fetch_o,
  output logic      [rcc_pkg::ADDR_W-1:0]  vector_addr_o,
  output logic                             trim_req_o,
  output logic      [TRIM_W-1:0]           ladder_trim_o,
  output logic                             ext_reset_disable_o,
  output logic                             reset_area_o,
  output logic                             reset_vector_sel_o
);
  import rcc_pkg::*;

  // ==========================================================================
  // state
  typedef struct packed {
    logic [CFG_W-1:0]  pend;    // uncommitted configuration
    logic [CFG_W-1:0]  act;     // committed configuration
    logic              fclr;    // pending flag clear request
    logic [FLAG_W-1:0] flags;   // reset cause flags
    logic [DATA_W-1:0] rd_data;
    logic              cpu_run;
    logic              fetch;
    logic              wu_act;
    logic              treq;
    logic [ADDR_W-1:0] vaddr;
    logic [TRIM_W-1:0] ladder;
  } rcc_top_state_t;

  rcc_top_state_t r;
  rcc_top_state_t next_r;

  logic              ext_rst;
  logic              int_rst;
  logic              soft_rst;
  logic              hold;
  logic              key_wr;
  logic              flag_clr;
  logic [FLAG_W-1:0] set_vec;

  if (WARMUP_CYCLES < 2 || TRIM_W < 1) begin : g_chk
    $error("warm-up length or trim width out of range");
  end

  // ==========================================================================
  // reset merge
  // an ignored external pin is masked here, so it never reaches the flags
  assign ext_rst  = !ext_reset_n_i && !r.act[CFG_RSTDIS_BIT];
  assign int_rst  = wdt_reset_i | clk_fault_reset_i | vdet1_reset_i |
                    vdet2_reset_i | trim_reset_i;
  assign soft_rst = ext_rst | int_rst;
  assign hold     = !rst_n_i | soft_rst;
  assign key_wr   = wr_i && (addr_i == KEY_ADDR);

  // cause events, set on the same bit order as the readback
  always_comb begin
    set_vec            = '0;
    set_vec[F_WDT]     = wdt_reset_i;
    set_vec[F_CLK]     = clk_fault_reset_i;
    set_vec[F_VDET1]   = vdet1_reset_i;
    set_vec[F_VDET2]   = vdet2_reset_i;
    set_vec[F_TRIM]    = trim_reset_i;
    set_vec[F_BADTRIM] = bad_trim_i;
  end

  // ==========================================================================
  // warm-up sequencer
  rcc_wu_if wu ();

  assign wu.hold = hold;

  rcc_warmup #(
    .WARMUP_CYCLES (WARMUP_CYCLES)
  ) u_warmup (
    .core_clk_i (core_clk_i),
    .wu         (wu)
  );

  // ==========================================================================
  // next state
  always_comb begin
    next_r         = r;
    flag_clr       = 1'b0;
    next_r.rd_data = REG_RST;
    // read data stands for exactly one cycle after the strobe
    if (rd_i) begin
      case (addr_i)
        CAUSE_ADDR: next_r.rd_data = {2'b00, r.flags};
        CFG_ADDR:   next_r.rd_data = {5'h00, r.pend};
        KEY_ADDR:   next_r.rd_data = {5'h00, r.act};
        default:    next_r.rd_data = REG_RST;
      endcase
    end
    // plain register writes
    if (wr_i && addr_i == CFG_ADDR) begin
      next_r.pend = wr_data_i[CFG_W-1:0];
    end
    if (wr_i && addr_i == CAUSE_ADDR) begin
      next_r.fclr = wr_data_i[FCLR_BIT];
    end
    // keyed commit copies the present pending value at the write edge
    if (key_wr) begin
      case (wr_data_i)
        KEY_RSTDIS: begin
          next_r.act[CFG_RSTDIS_BIT] = r.pend[CFG_RSTDIS_BIT];
        end
        KEY_AREA: begin
          next_r.act[CFG_AREA_BIT] = r.pend[CFG_AREA_BIT];
          next_r.act[CFG_VEC_BIT]  = r.pend[CFG_VEC_BIT];
        end
        KEY_FCLR: begin
          if (r.fclr) begin
            flag_clr    = 1'b1;
            next_r.fclr = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    // a new event in the clearing cycle still sets its flag; an internal
    // reset keeps the older ones so software can read them later
    next_r.flags = ((flag_clr || ext_rst) ? '0 : r.flags) | set_vec;
    // non-power-on resets drop pending settings but not the committed
    // disable, otherwise the pin could re-arm itself mid-reset
    if (soft_rst) begin
      next_r.pend              = '0;
      next_r.fclr              = 1'b0;
      next_r.act[CFG_AREA_BIT] = 1'b0;
      next_r.act[CFG_VEC_BIT]  = 1'b0;
    end
    // release sequence, identical for every source
    next_r.cpu_run = wu.done && !hold;
    next_r.fetch   = wu.done && !hold && !r.cpu_run;
    next_r.wu_act  = wu.busy && !hold;
    next_r.treq    = wu.trim_start && !hold;
    if (next_r.fetch) begin
      next_r.vaddr = RESET_VECTOR_ADDR;
    end
    if (trim_valid_i && wu.busy && !hold) begin
      next_r.ladder = trim_data_i;
    end
  end

  // power-on reset clears everything, including the committed disable
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // ==========================================================================
  // outputs
  assign rd_data_o           = r.rd_data;
  assign cpu_reset_n_o       = r.cpu_run;
  assign periph_reset_n_o    = r.cpu_run;
  assign warmup_active_o     = r.wu_act;
  assign vector_fetch_o      = r.fetch;
  assign vector_addr_o       = r.vaddr;
  assign trim_req_o          = r.treq;
  assign ladder_trim_o       = r.ladder;
  assign ext_reset_disable_o = r.act[CFG_RSTDIS_BIT];
  assign reset_area_o        = r.act[CFG_AREA_BIT];
  assign reset_vector_sel_o  = r.act[CFG_VEC_BIT];

  // ==========================================================================
  // checks
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  property p_rstdis_commit;
    key_wr && wr_data_i == KEY_RSTDIS |=>
      ext_reset_disable_o == $past(r.pend[CFG_RSTDIS_BIT]);
  endproperty
  a_rstdis_commit: assert property (p_rstdis_commit)
    else $error("disable commit wrong");

  property p_area_commit;
    key_wr && wr_data_i == KEY_AREA && !soft_rst |=>
      {reset_vector_sel_o, reset_area_o} ==
      $past(r.pend[CFG_VEC_BIT:CFG_AREA_BIT]);
  endproperty
  a_area_commit: assert property (p_area_commit)
    else $error("area commit wrong");

  property p_bad_key;
    key_wr && wr_data_i != KEY_RSTDIS && wr_data_i != KEY_AREA &&
      !soft_rst |=> $stable(r.act);
  endproperty
  a_bad_key: assert property (p_bad_key)
    else $error("invalid key changed settings");

  property p_readback;
    rd_i && addr_i == KEY_ADDR |=>
      rd_data_o == {5'h00, $past(r.act)};
  endproperty
  a_readback: assert property (p_readback)
    else $error("readback mismatch");

  property p_cfg_read;
    rd_i && addr_i == CFG_ADDR |=> rd_data_o[7:3] == 5'h00;
  endproperty
  a_cfg_read: assert property (p_cfg_read)
    else $error("config upper bits not zero");

  property p_dis_keep;
    soft_rst && !key_wr |=> $stable(ext_reset_disable_o) && r.pend == '0;
  endproperty
  a_dis_keep: assert property (p_dis_keep)
    else $error("disable lost on non power-on reset");

  property p_flag_set;
    wdt_reset_i |=> r.flags[F_WDT];
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("watchdog flag not set");

  property p_flag_hold;
    int_rst && !ext_rst && !key_wr |=> (r.flags & $past(r.flags)) ==
      $past(r.flags);
  endproperty
  a_flag_hold: assert property (p_flag_hold)
    else $error("internal reset cleared a flag");

  property p_fclr;
    key_wr && wr_data_i == KEY_FCLR && r.fclr && set_vec == '0 |=>
      r.flags == '0 && !r.fclr;
  endproperty
  a_fclr: assert property (p_fclr)
    else $error("keyed clear failed");

  property p_cause_read;
    rd_i && addr_i == CAUSE_ADDR |=> rd_data_o[7:6] == 2'b00;
  endproperty
  a_cause_read: assert property (p_cause_read)
    else $error("cause upper bits not zero");

  property p_hold_cpu;
    hold |=> !cpu_reset_n_o && !periph_reset_n_o;
  endproperty
  a_hold_cpu: assert property (p_hold_cpu)
    else $error("cpu released during reset");

  property p_wu_start;
    $fell(hold) ##1 !hold |=> warmup_active_o;
  endproperty
  a_wu_start: assert property (p_wu_start)
    else $error("warm-up did not start");

  property p_wu_restart;
    hold ##1 hold |=> !warmup_active_o;
  endproperty
  a_wu_restart: assert property (p_wu_restart)
    else $error("warm-up not cleared by reset");

  property p_fetch;
    vector_fetch_o |-> cpu_reset_n_o && vector_addr_o == RESET_VECTOR_ADDR;
  endproperty
  a_fetch: assert property (p_fetch)
    else $error("vector fetch wrong");

endmodule
`default_nettype wire

/* inc/rcc_pkg.sv */
// shared constants and types of the reset control and cause flag block
package rcc_pkg;

  // ==========================================================================
  // register map and widths
  localparam int          ADDR_W     = 16;
  localparam int          DATA_W     = 8;
  localparam logic [15:0] CAUSE_ADDR = 16'h0fcc;
  localparam logic [15:0] CFG_ADDR   = 16'h0fde;
  localparam logic [15:0] KEY_ADDR   = 16'h0fdf;
  localparam logic [7:0]  REG_RST    = 8'h00;

  // ==========================================================================
  // key codes
  localparam logic [7:0] KEY_RSTDIS = 8'hb2;
  localparam logic [7:0] KEY_AREA   = 8'hd4;
  localparam logic [7:0] KEY_FCLR   = 8'h71;

  // ==========================================================================
  // field positions
  localparam int CFG_W          = 3;
  localparam int CFG_RSTDIS_BIT = 0;
  localparam int CFG_AREA_BIT   = 1;
  localparam int CFG_VEC_BIT    = 2;
  localparam int FLAG_W         = 6;
  localparam int FCLR_BIT       = 7;
  localparam int F_WDT          = 0;
  localparam int F_CLK          = 1;
  localparam int F_VDET1        = 2;
  localparam int F_VDET2        = 3;
  localparam int F_TRIM         = 4;
  localparam int F_BADTRIM      = 5;

  // ==========================================================================
  // sequence constants
  localparam logic [15:0] RESET_VECTOR_ADDR = 16'hfffe;
  localparam int          WARMUP_CYCLES_DEF = 1024;
  localparam int          TRIM_W_DEF        = 8;

  // warm-up sequencer states
  typedef enum logic [2:0] {
    WU_HOLD  = 3'b001,
    WU_COUNT = 3'b010,
    WU_RUN   = 3'b100
  } rcc_wu_st_t;

endpackage

/* inc/rcc_wu_if.sv */
// carrier between the reset controller and its warm-up sequencer
`timescale 1ns/10ps
`default_nettype none
interface rcc_wu_if;
  logic hold;       // any reset asserted
  logic busy;       // warm-up running
  logic done;       // warm-up finished, level
  logic trim_start; // one-cycle pulse at warm-up start

  modport ctl (output hold, input busy, input done, input trim_start);
  modport wu  (input hold, output busy, output done, output trim_start);
endinterface
`default_nettype wire

/* verilog/rcc_warmup.sv */
// warm-up sequencer: counts high-frequency clock cycles after reset release
`timescale 1ns/10ps
`default_nettype none
module rcc_warmup #(
  parameter int WARMUP_CYCLES = rcc_pkg::WARMUP_CYCLES_DEF
) (
  input wire logic core_clk_i,
  rcc_wu_if.wu     wu
);
  import rcc_pkg::*;

  localparam int CW = $clog2(WARMUP_CYCLES + 1);

  // ==========================================================================
  // state
  typedef struct packed {
    rcc_wu_st_t      st;
    logic [CW-1:0]   cnt;
    logic            busy;
    logic            done;
    logic            tstart;
  } rcc_wu_state_t;

  rcc_wu_state_t r;
  rcc_wu_state_t next_r;

  if (WARMUP_CYCLES < 2) begin : g_chk
    $error("warm-up needs at least two cycles");
  end

  // hold acts as the sequencer's own synchronous clear
  always_comb begin
    next_r        = r;
    next_r.tstart = 1'b0;
    case (r.st)
      WU_HOLD: begin
        if (!wu.hold) begin
          next_r.st     = WU_COUNT;
          next_r.busy   = 1'b1;
          next_r.tstart = 1'b1;
        end
      end
      WU_COUNT: begin
        next_r.cnt = r.cnt + CW'(1);
        if (r.cnt == CW'(WARMUP_CYCLES - 1)) begin
          next_r.st   = WU_RUN;
          next_r.busy = 1'b0;
          next_r.done = 1'b1;
        end
      end
      WU_RUN: begin
        next_r.done = 1'b1;
      end
      default: begin
        next_r.st = WU_HOLD;
      end
    endcase
    // a reset at any point drops the count so warm-up starts over
    if (wu.hold) begin
      next_r.st     = WU_HOLD;
      next_r.cnt    = '0;
      next_r.busy   = 1'b0;
      next_r.done   = 1'b0;
      next_r.tstart = 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    r <= next_r;
  end

  assign wu.busy       = r.busy;
  assign wu.done       = r.done;
  assign wu.trim_start = r.tstart;

endmodule
`default_nettype wire

/* tb/tb_rcc_top.sv */
// self-checking bench of the reset control and cause flag block
`timescale 1ns/10ps
`default_nettype none
module tb_rcc_top;
  import rcc_pkg::*;
  // ==========================================================================
  // signals; short warm-up keeps every reset sequence brief
  localparam int WU = 4;
  logic        core_clk_i = 1'b0;
  logic        rst_n_i;
  logic        ext_reset_n_i;
  logic [4:0]  irst;
  logic        bad_trim_i;
  logic        trim_valid_i;
  logic [7:0]  trim_data_i;
  logic [15:0] addr_i;
  logic [7:0]  wr_data_i;
  logic        wr_i;
  logic        rd_i;
  logic [7:0]  rd_data_o;
  logic        cpu_n;
  logic        periph_n;
  logic        wu_act;
  logic        fetch;
  logic [15:0] vec_addr;
  logic        trim_req;
  logic [7:0]  ladder;
  logic        dis;
  logic        area;
  logic        vsel;
  logic [7:0]  exp_q[$];
  logic        rd_pend = 1'b0;
  logic [7:0]  lfsr = 8'h41;
  logic [7:0]  flags = 8'h00;
  logic [7:0]  keep;
  int          miscompares = 0;
  int          check_count = 0;
  int          n;

  rcc_top #(.WARMUP_CYCLES(WU), .TRIM_W(8)) rcc_top_inst (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .ext_reset_n_i(ext_reset_n_i), .wdt_reset_i(irst[0]),
    .clk_fault_reset_i(irst[1]), .vdet1_reset_i(irst[2]),
    .vdet2_reset_i(irst[3]), .trim_reset_i(irst[4]),
    .bad_trim_i(bad_trim_i), .trim_valid_i(trim_valid_i),
    .trim_data_i(trim_data_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
    .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o),
    .cpu_reset_n_o(cpu_n), .periph_reset_n_o(periph_n),
    .warmup_active_o(wu_act), .vector_fetch_o(fetch),
    .vector_addr_o(vec_addr), .trim_req_o(trim_req),
    .ladder_trim_o(ladder), .ext_reset_disable_o(dis),
    .reset_area_o(area), .reset_vector_sel_o(vsel)
  );

  initial begin
    forever #2.5 core_clk_i = ~core_clk_i;
  end

  // ==========================================================================
  // comparison, closing and random helpers
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // lfsr keeps the random stream repeatable from run to run
  function automatic void rnd();
    lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
  endfunction

  // ==========================================================================
  // register bus: one-cycle strobes, a gap cycle between calls
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    wr_i      <= 1'b1;
    addr_i    <= a;
    wr_data_i <= d;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
    #1;
  endtask

  // the expected byte is queued; the monitor takes it when data appear
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge core_clk_i);
    rd_i   <= 1'b1;
    addr_i <= a;
    exp_q.push_back(e);
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    #1;
  endtask

  // read data stand only in the cycle after the strobe, so look mid-cycle
  always @(negedge core_clk_i) begin
    if (rd_pend) begin
      check(rd_data_o, exp_q.pop_front());
    end
    rd_pend = rd_i;
  end

  // ==========================================================================
  // reset sources: index 0..4 internal, 5 the external pin
  task automatic hold_src(input int i, input logic exp_cpu);
    @(posedge core_clk_i);
    rnd();
    trim_data_i <= lfsr;
    if (i < 5) begin
      irst[i] <= 1'b1;
    end else begin
      ext_reset_n_i <= 1'b0;
    end
    @(posedge core_clk_i);
    irst          <= 5'h00;
    ext_reset_n_i <= 1'b1;
    #1;
    check(16'(cpu_n), 16'(exp_cpu));
    check(16'(periph_n), 16'(exp_cpu));
  endtask

  task automatic bad_pulse();
    @(posedge core_clk_i);
    bad_trim_i <= 1'b1;
    @(posedge core_clk_i);
    bad_trim_i <= 1'b0;
    #1;
    check(16'(cpu_n), 16'h1);
  endtask

  // count cycles from release to the vector fetch, bounded at 64
  task automatic wait_fetch();
    logic seen_wu;
    logic seen_tr;
    n = 0;
    seen_wu = 1'b0;
    seen_tr = 1'b0;
    while (fetch !== 1'b1 && n < 64) begin
      @(posedge core_clk_i);
      #1;
      n++;
      seen_wu |= (wu_act === 1'b1);
      seen_tr |= (trim_req === 1'b1);
    end
    check(16'(seen_wu), 16'h1);
    check(16'(seen_tr), 16'h1);
    check(16'(n >= WU && n <= WU + 4), 16'h1);
    check(16'(cpu_n & periph_n), 16'h1);
    check(vec_addr, RESET_VECTOR_ADDR);
    check(16'(ladder), 16'(trim_data_i));
  endtask

  task automatic por();
    @(posedge core_clk_i);
    rst_n_i <= 1'b0;
    repeat (4) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    #1;
    check(16'(dis), 16'h0);
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    rst_n_i = 1'b0;
    ext_reset_n_i = 1'b1;
    irst = 5'h00;
    bad_trim_i = 1'b0;
    trim_valid_i = 1'b1;
    trim_data_i = 8'h00;
    addr_i = 16'h0000;
    wr_data_i = 8'h00;
    wr_i = 1'b0;
    rd_i = 1'b0;
    por();
    wait_fetch();
    rd(CAUSE_ADDR, 8'h00);
    rd(CFG_ADDR, 8'h00);
    rd(KEY_ADDR, 8'h00);
    rd(16'h0fcd, 8'h00);
    rnd();
    wr(CFG_ADDR, lfsr);
    rd(CFG_ADDR, lfsr & 8'h07);
    wr(CFG_ADDR, 8'h07);
    // stray keys must leave every committed bit alone
    for (int i = 0; i < 8; i++) begin
      rnd();
      if (!(lfsr inside {KEY_RSTDIS, KEY_AREA, KEY_FCLR})) begin
        wr(KEY_ADDR, lfsr);
        check(16'({dis, area, vsel}), 16'h0);
      end
    end
    // keys go out as plain byte writes at the one core clock rate
    wr(KEY_ADDR, KEY_RSTDIS);
    check(16'({dis, area, vsel}), 16'h4);
    rd(KEY_ADDR, 8'h01);
    wr(KEY_ADDR, KEY_AREA);
    check(16'({dis, area, vsel}), 16'h7);
    rd(KEY_ADDR, 8'h07);
    wr(CAUSE_ADDR, 8'hff);
    rd(CAUSE_ADDR, 8'h00);
    // each internal source sets its own flag and keeps the older ones
    for (int i = 0; i < 5; i++) begin
      hold_src(i, 1'b0);
      wait_fetch();
      flags[i] = 1'b1;
      rd(CAUSE_ADDR, flags);
      rd(CFG_ADDR, 8'h00);
      rd(KEY_ADDR, 8'h01);
    end
    bad_pulse();
    flags[5] = 1'b1;
    rd(CAUSE_ADDR, flags);
    // a second reset mid warm-up must restart the count
    hold_src(0, 1'b0);
    repeat (2) @(posedge core_clk_i);
    hold_src(0, 1'b0);
    wait_fetch();
    hold_src(5, 1'b1);
    rd(CAUSE_ADDR, flags);
    wr(KEY_ADDR, KEY_FCLR);
    rd(CAUSE_ADDR, flags);
    wr(CAUSE_ADDR, 8'h80);
    wr(KEY_ADDR, KEY_FCLR);
    rd(CAUSE_ADDR, 8'h00);
    bad_pulse();
    wr(KEY_ADDR, KEY_FCLR);
    rd(CAUSE_ADDR, 8'h20);
    por();
    wait_fetch();
    rd(CAUSE_ADDR, 8'h00);
    hold_src(0, 1'b0);
    wait_fetch();
    hold_src(5, 1'b0);
    wait_fetch();
    rd(CAUSE_ADDR, 8'h00);
    // a trim word offered with valid low must not reach the ladder
    trim_valid_i <= 1'b0;
    keep = ladder;
    hold_src(1, 1'b0);
    repeat (WU + 3) @(posedge core_clk_i);
    #1;
    check(16'(ladder), 16'(keep));
    check(16'(cpu_n), 16'h1);
    trim_valid_i <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    final_report();
  end

  // watchdog: the whole run needs well under a thousand cycles
  initial begin
    #100000;
    miscompares++;
    final_report();
  end
endmodule
`default_nettype wire
